// ===== ops_cfg.svh
`ifndef OPS_CFG_SVH
`define OPS_CFG_SVH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define OPC_CVT_RZ 8'h77
`define OPC_CVT_RZ_FLAGS 8'h78
`define OPC_GEQ 8'h23
`define OPC_GEQ_IMM 8'h24

// ----------------------------------------------------------------
// unit timing and issue slots (bit n is slot n+1)
// ----------------------------------------------------------------
`define FALU_LATENCY 3
`define ALU_LATENCY 1
`define FALU_SLOT_MASK 5'h09
`define ALU_SLOT_MASK 5'h1f
`define SLOT_FIRST 3'h1
`define SLOT_LAST 3'h5

// ----------------------------------------------------------------
// exception flag layout
// ----------------------------------------------------------------
`define FLAG_W 6
`define FLAG_INX 1
`define FLAG_INV 4
`define FLAG_IFZ 5
`define FLAGS_RESET 6'h00

// ----------------------------------------------------------------
// single precision packing
// ----------------------------------------------------------------
`define EXP_TOP 8'h9e
`define MANT_W 23

// ----------------------------------------------------------------
// register map and event bits
// ----------------------------------------------------------------
`define ADDR_W 8
`define ADDR_FLAGS 8'h00
`define ADDR_IRQ_STATUS 8'h04
`define ADDR_IRQ_MASK 8'h08
`define EVT_W 2
`define EVT_INEXACT 0
`define EVT_BAD_ISSUE 1
`define EVT_RESET 2'h0

`endif

// ===== ops_pkg.sv
package ops_pkg;

  // kind of operation accepted at issue
  typedef enum logic [2:0] {
    OP_NONE,
    OP_CVT,
    OP_CVT_FLAGS,
    OP_GEQ,
    OP_GEQ_IMM
  } op_kind_t;

endpackage

// ===== u2f_rz.sv
`timescale 1ns/1ps
`include "ops_cfg.svh"

module u2f_rz (
  // operand
  input wire logic [31:0] src_i,
  // converted value and its exception flags
  output logic [31:0] result_o,
  output logic [`FLAG_W-1:0] flags_o
);

  logic [4:0] lead_zeros;
  logic found;
  logic [31:0] norm;
  logic [7:0] expo;

  // ----------------------------------------------------------------
  // leading one search and normalisation
  // ----------------------------------------------------------------
  always_comb begin
    lead_zeros = 5'h00;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found && src_i[i]) begin
        lead_zeros = 5'(31 - i);
        found = 1'b1;
      end
    end
  end

  assign norm = src_i << lead_zeros;
  assign expo = `EXP_TOP - {3'h0, lead_zeros};

  // truncating pack
  // dropped low bits are simply discarded
  always_comb begin
    if (found) begin
      result_o = {1'b0, expo, norm[30:8]};
    end else begin
      result_o = 32'h0;
    end
  end

  always_comb begin
    flags_o = `FLAGS_RESET;
    flags_o[`FLAG_INX] = |norm[7:0];
  end

endmodule

// ===== exc_sticky.sv
`timescale 1ns/1ps
`include "ops_cfg.svh"

module exc_sticky #(
  parameter int W = `FLAG_W
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // explicit status word write
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  // all simultaneous flag updates, already ored
  input wire logic [W-1:0] set_i,
  // held flags
  output logic [W-1:0] flags_o
);

  logic [W-1:0] flags_r;

  // or with old value
  // a set arriving with the write still lands
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_r <= W'(`FLAGS_RESET);
    end else begin
      flags_r <= (wr_i ? wdata_i : flags_r) | set_i;
    end
  end

  assign flags_o = flags_r;

endmodule

// ===== unsigned_convert_compare_ops.sv
// How it works
// - convert unsigned 32-bit to single float, always truncating toward zero
// - conversion is opcode 119, one operand, float unit, 3 cycles, slots 1,4
// - conversion exceptions set status word flags that stay until written
// - flag update lands in the same cycle as the destination write
// - simultaneous float flag updates are ored with the held flags
// - conversion guard bit 0 low suppresses both write and flag update
// - flags-only conversion writes the exception vector in status layout
// - flags-only conversion never touches status flags, ignores rounding mode
// - flags-only conversion is opcode 120, float unit, 3 cycles, slots 1,4
// - register compare writes 1 when first >= second unsigned, else 0
// - register compare is opcode 35, two operands, integer unit, 1 cycle
// - immediate compare writes 1 when source >= 7-bit modifier, else 0
// - immediate compare is opcode 36, integer unit, 1 cycle, slots 1-5
// - guard bit 0 decides the destination write for the other ops
`timescale 1ns/1ps
`include "ops_cfg.svh"

module unsigned_convert_compare_ops #(
  parameter int DEST_W = 7,
  parameter int FALU_LAT = `FALU_LATENCY
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // issue
  input wire logic issue_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [2:0] slot_i,
  input wire logic guard_present_i,
  input wire logic [31:0] guard_i,
  input wire logic [31:0] first_source_i,
  input wire logic [31:0] second_source_i,
  input wire logic [6:0] modifier_i,
  input wire logic [DEST_W-1:0] dest_i,
  // flag updates from other float operations
  input wire logic [`FLAG_W-1:0] fp_flag_set_i,
  // integer unit write port
  output logic alu_wr_en_o,
  output logic [DEST_W-1:0] alu_wr_dest_o,
  output logic [31:0] alu_wr_data_o,
  // float unit write port
  output logic falu_wr_en_o,
  output logic [DEST_W-1:0] falu_wr_dest_o,
  output logic [31:0] falu_wr_data_o,
  // status word exception flags
  output logic [`FLAG_W-1:0] exc_flags_o,
  // register port
  input wire logic [`ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // interrupt
  output logic irq_o
);

  import ops_pkg::*;

  // ----------------------------------------------------------------
  // issue decode
  // ----------------------------------------------------------------
  op_kind_t kind;
  logic [4:0] slot_mask;
  logic slot_ok;
  logic guard_true;
  logic take;
  logic bad_issue;

  always_comb begin
    kind = OP_NONE;
    slot_mask = 5'h00;
    if (issue_valid_i) begin
      unique case (opcode_i)
        `OPC_CVT_RZ: begin
          kind = OP_CVT;
          slot_mask = `FALU_SLOT_MASK;
        end
        `OPC_CVT_RZ_FLAGS: begin
          kind = OP_CVT_FLAGS;
          slot_mask = `FALU_SLOT_MASK;
        end
        `OPC_GEQ: begin
          kind = OP_GEQ;
          slot_mask = `ALU_SLOT_MASK;
        end
        `OPC_GEQ_IMM: begin
          kind = OP_GEQ_IMM;
          slot_mask = `ALU_SLOT_MASK;
        end
        default: begin
          kind = OP_NONE;
          slot_mask = 5'h00;
        end
      endcase
    end
  end

  // slot numbers run from 1; out of range never matches
  always_comb begin
    slot_ok = 1'b0;
    if (slot_i >= `SLOT_FIRST && slot_i <= `SLOT_LAST) begin
      slot_ok = slot_mask[3'(slot_i - `SLOT_FIRST)];
    end
  end

  assign guard_true = !guard_present_i || guard_i[0];

  assign take = (kind != OP_NONE) && slot_ok && guard_true;

  // known op in a slot it cannot use: dropped and reported
  assign bad_issue = (kind != OP_NONE) && !slot_ok;

  // ----------------------------------------------------------------
  // conversion datapath
  // ----------------------------------------------------------------
  logic [31:0] cvt_result;
  logic [`FLAG_W-1:0] cvt_flags;

  u2f_rz u_cvt (
    .src_i(first_source_i),
    .result_o(cvt_result),
    .flags_o(cvt_flags)
  );

  // ----------------------------------------------------------------
  // integer unit, one cycle
  // ----------------------------------------------------------------
  logic alu_take;
  logic geq_bit;
  logic alu_wr_en_r;
  logic [DEST_W-1:0] alu_wr_dest_r;
  logic [31:0] alu_wr_data_r;

  assign alu_take = take && (kind == OP_GEQ || kind == OP_GEQ_IMM);

  always_comb begin
    geq_bit = 1'b0;
    if (kind == OP_GEQ) begin
      geq_bit = first_source_i >= second_source_i;
    end else begin
      geq_bit = first_source_i >= {25'h0, modifier_i};
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alu_wr_en_r <= 1'b0;
      alu_wr_dest_r <= '0;
      alu_wr_data_r <= 32'h0;
    end else begin
      alu_wr_en_r <= alu_take;
      if (alu_take) begin
        alu_wr_dest_r <= dest_i;
        alu_wr_data_r <= {31'h0, geq_bit};
      end
    end
  end

  // ----------------------------------------------------------------
  // float unit pipeline
  // ----------------------------------------------------------------
  logic falu_take;
  logic [31:0] falu_data;
  logic st_valid_r [FALU_LAT];
  logic st_upd_r [FALU_LAT];
  logic [DEST_W-1:0] st_dest_r [FALU_LAT];
  logic [31:0] st_data_r [FALU_LAT];
  logic [`FLAG_W-1:0] st_flags_r [FALU_LAT];

  assign falu_take = take && (kind == OP_CVT || kind == OP_CVT_FLAGS);

  always_comb begin
    if (kind == OP_CVT) begin
      falu_data = cvt_result;
    end else begin
      falu_data = {{(32 - `FLAG_W){1'b0}}, cvt_flags};
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_valid_r[0] <= 1'b0;
      st_upd_r[0] <= 1'b0;
      st_dest_r[0] <= '0;
      st_data_r[0] <= 32'h0;
      st_flags_r[0] <= `FLAGS_RESET;
    end else begin
      st_valid_r[0] <= falu_take;
      st_upd_r[0] <= falu_take && (kind == OP_CVT);
      st_dest_r[0] <= dest_i;
      st_data_r[0] <= falu_data;
      st_flags_r[0] <= cvt_flags;
    end
  end

  genvar g;
  generate
    for (g = 1; g < FALU_LAT; g++) begin : g_stage
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          st_valid_r[g] <= 1'b0;
          st_upd_r[g] <= 1'b0;
          st_dest_r[g] <= '0;
          st_data_r[g] <= 32'h0;
          st_flags_r[g] <= `FLAGS_RESET;
        end else begin
          st_valid_r[g] <= st_valid_r[g-1];
          st_upd_r[g] <= st_upd_r[g-1];
          st_dest_r[g] <= st_dest_r[g-1];
          st_data_r[g] <= st_data_r[g-1];
          st_flags_r[g] <= st_flags_r[g-1];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // status word flags
  // ----------------------------------------------------------------
  logic [`FLAG_W-1:0] own_set;
  logic [`FLAG_W-1:0] all_set;
  logic flags_wr;

  // update beside final stage
  // taken from the stage loaded into the write port on the same edge
  assign own_set = st_upd_r[FALU_LAT-2] ? st_flags_r[FALU_LAT-2] : '0;

  assign all_set = own_set | fp_flag_set_i;

  assign flags_wr = reg_wr_i && (reg_addr_i == `ADDR_FLAGS);

  exc_sticky #(
    .W(`FLAG_W)
  ) u_flags (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .wr_i(flags_wr),
    .wdata_i(reg_wdata_i[`FLAG_W-1:0]),
    .set_i(all_set),
    .flags_o(exc_flags_o)
  );

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  logic [`EVT_W-1:0] evt;
  logic [`EVT_W-1:0] irq_status_r;
  logic [`EVT_W-1:0] irq_status_nxt;
  logic [`EVT_W-1:0] irq_mask_r;
  logic [`EVT_W-1:0] irq_mask_nxt;
  logic [`EVT_W-1:0] w1c;
  logic irq_r;

  always_comb begin
    evt = `EVT_RESET;
    evt[`EVT_INEXACT] = own_set[`FLAG_INX];
    evt[`EVT_BAD_ISSUE] = bad_issue;
  end

  always_comb begin
    w1c = '0;
    if (reg_wr_i && reg_addr_i == `ADDR_IRQ_STATUS) begin
      w1c = reg_wdata_i[`EVT_W-1:0];
    end
    // a new event wins over its clear
    irq_status_nxt = (irq_status_r & ~w1c) | evt;
    irq_mask_nxt = irq_mask_r;
    if (reg_wr_i && reg_addr_i == `ADDR_IRQ_MASK) begin
      irq_mask_nxt = reg_wdata_i[`EVT_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status_r <= `EVT_RESET;
      irq_mask_r <= `EVT_RESET;
      irq_r <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= |(irq_status_nxt & irq_mask_nxt);
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [31:0] rdata_r;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 32'h0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `ADDR_FLAGS: begin
          rdata_r <= {{(32 - `FLAG_W){1'b0}}, exc_flags_o};
        end
        `ADDR_IRQ_STATUS: begin
          rdata_r <= {{(32 - `EVT_W){1'b0}}, irq_status_r};
        end
        `ADDR_IRQ_MASK: begin
          rdata_r <= {{(32 - `EVT_W){1'b0}}, irq_mask_r};
        end
        default: begin
          rdata_r <= 32'h0;
        end
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign alu_wr_en_o = alu_wr_en_r;
  assign alu_wr_dest_o = alu_wr_dest_r;
  assign alu_wr_data_o = alu_wr_data_r;
  assign falu_wr_en_o = st_valid_r[FALU_LAT-1];
  assign falu_wr_dest_o = st_dest_r[FALU_LAT-1];
  assign falu_wr_data_o = st_data_r[FALU_LAT-1];
  assign reg_rdata_o = rdata_r;
  assign irq_o = irq_r;

endmodule

// ===== ops_checker.sv
`timescale 1ns/1ps
`include "ops_cfg.svh"

module ops_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // issue
  input wire logic issue_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [2:0] slot_i,
  input wire logic guard_present_i,
  input wire logic [31:0] guard_i,
  input wire logic [31:0] first_source_i,
  input wire logic [31:0] second_source_i,
  input wire logic [6:0] modifier_i,
  input wire logic [`FLAG_W-1:0] fp_flag_set_i,
  // results
  input wire logic alu_wr_en_o,
  input wire logic [31:0] alu_wr_data_o,
  input wire logic falu_wr_en_o,
  input wire logic [`FLAG_W-1:0] exc_flags_o,
  // register port
  input wire logic [`ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // ------------
  // issue decode
  // ------------
  logic go, fop, fok, aok, ge, gei;
  assign go = issue_valid_i && (!guard_present_i || guard_i[0]);
  assign fop = opcode_i == `OPC_CVT_RZ || opcode_i == `OPC_CVT_RZ_FLAGS;
  assign fok = slot_i == 3'h1 || slot_i == 3'h4;
  assign aok = slot_i >= `SLOT_FIRST && slot_i <= `SLOT_LAST;
  assign ge = first_source_i >= second_source_i;
  assign gei = first_source_i >= {25'h0, modifier_i};

  // ------------
  // properties
  // ------------
  a_geq_result: assert property (
    go && aok && opcode_i == `OPC_GEQ
    |=> alu_wr_en_o && alu_wr_data_o == {31'h0, $past(ge)})
    else $error("register compare result wrong");
  a_geqi_result: assert property (
    go && aok && opcode_i == `OPC_GEQ_IMM
    |=> alu_wr_en_o && alu_wr_data_o == {31'h0, $past(gei)})
    else $error("immediate compare result wrong");
  a_cvt_latency: assert property (
    go && fok && fop |-> ##3 falu_wr_en_o)
    else $error("float write not three cycles after issue");
  a_alu_guarded: assert property (
    issue_valid_i && guard_present_i && !guard_i[0] |=> !alu_wr_en_o)
    else $error("compare wrote with false guard");
  a_falu_refused: assert property (
    issue_valid_i && fop && !(go && fok) |-> ##3 !falu_wr_en_o)
    else $error("float write despite guard or slot");
  a_flags_sticky: assert property (
    !(reg_wr_i && reg_addr_i == `ADDR_FLAGS)
    |=> (exc_flags_o & $past(exc_flags_o)) == $past(exc_flags_o))
    else $error("flag dropped without status write");
  a_flags_ored: assert property (
    fp_flag_set_i != 6'h00
    |=> (exc_flags_o & $past(fp_flag_set_i)) == $past(fp_flag_set_i))
    else $error("external flag update lost");
  a_inexact_with_write: assert property (
    $rose(exc_flags_o[`FLAG_INX])
    |-> falu_wr_en_o || $past(fp_flag_set_i[`FLAG_INX]) || $past(reg_wr_i))
    else $error("inexact rose apart from its write");
  a_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
endmodule

bind unsigned_convert_compare_ops ops_checker u_chk (.*);

// ===== regfile_model.sv
`timescale 1ns/1ps

module regfile_model #(
  parameter int DEST_W = 7
) (
  // clock
  input wire logic clock_i,
  // write ports
  input wire logic alu_wr_en_i,
  input wire logic [DEST_W-1:0] alu_wr_dest_i,
  input wire logic [31:0] alu_wr_data_i,
  input wire logic falu_wr_en_i,
  input wire logic [DEST_W-1:0] falu_wr_dest_i,
  input wire logic [31:0] falu_wr_data_i
);
  // known fill so unwritten entries are visible
  logic [31:0] rf [2**DEST_W];
  initial begin
    for (int i = 0; i < 2**DEST_W; i++) rf[i] = 32'hc0de0000 | 32'(i);
  end
  always @(posedge clock_i) begin
    if (alu_wr_en_i) rf[alu_wr_dest_i] <= alu_wr_data_i;
    if (falu_wr_en_i) rf[falu_wr_dest_i] <= falu_wr_data_i;
  end
endmodule

// ===== unsigned_convert_compare_ops_bench.sv
`timescale 1ns/1ps
`include "ops_cfg.svh"

module unsigned_convert_compare_ops_bench;
  logic clock_i = 0, rstn_i = 0, issue_valid_i = 0, guard_present_i = 0;
  logic [7:0] opcode_i = 8'h00, reg_addr_i = 8'h00;
  logic [2:0] slot_i = 3'h1;
  logic [31:0] guard_i = 32'h0, first_source_i = 32'h0;
  logic [31:0] second_source_i = 32'h0, reg_wdata_i = 32'h0;
  logic [6:0] modifier_i = 7'h00, dest_i = 7'h00;
  logic [5:0] fp_flag_set_i = 6'h00, exc_flags_o;
  logic reg_wr_i = 0, reg_rd_i = 0, alu_wr_en_o, falu_wr_en_o, irq_o;
  logic [6:0] alu_wr_dest_o, falu_wr_dest_o;
  logic [31:0] alu_wr_data_o, falu_wr_data_o, reg_rdata_o;
  int miscompares = 0, compares = 0;
  logic [31:0] ex [100];
  logic [7:0] opc [4] = '{`OPC_GEQ, `OPC_GEQ_IMM, `OPC_CVT_RZ,
    `OPC_CVT_RZ_FLAGS};
  logic [31:0] corner [6] = '{32'h3, 32'hffffffff, 32'h7fffffff,
    32'h80000000, 32'h7ffffff1, 32'h0};

  always #25 clock_i = ~clock_i;

  unsigned_convert_compare_ops dut (.*);
  regfile_model pm (.clock_i(clock_i), .alu_wr_en_i(alu_wr_en_o),
    .alu_wr_dest_i(alu_wr_dest_o), .alu_wr_data_i(alu_wr_data_o),
    .falu_wr_en_i(falu_wr_en_o), .falu_wr_dest_i(falu_wr_dest_o),
    .falu_wr_data_i(falu_wr_data_o));

  // ------------
  // helpers
  // ------------
  // {inexact, truncated single}
  function automatic logic [32:0] cvt(input logic [31:0] u);
    logic [31:0] n;
    int p;
    n = u;
    p = 31;
    if (u == 32'h0) return 33'h0;
    while (!n[31]) begin
      n = n << 1;
      p--;
    end
    return {n[7:0] != 8'h00, 1'b0, 8'(127 + p), n[30:8]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic iss(input int k, input logic [2:0] s, input logic gp,
    input logic g, input logic [31:0] a, input logic [31:0] b,
    input logic [6:0] m, input logic [6:0] d);
    issue_valid_i <= 1;
    opcode_i <= opc[k];
    slot_i <= s;
    guard_present_i <= gp;
    guard_i <= ($urandom & 32'hfffffffe) | 32'(g);
    first_source_i <= a;
    second_source_i <= b;
    modifier_i <= m;
    dest_i <= d;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_rd_i <= 1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 0;
    #1 v = reg_rdata_o;
    @(posedge clock_i);
  endtask

  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock_i);
    miscompares++;
    wrap_up;
  end

  // ------------
  // tests
  // ------------
  initial begin
    logic [31:0] v, a, b;
    logic [32:0] r;
    logic [6:0] m;
    logic [2:0] s;
    logic gp, g, inexact_flag;
    int k;
    v = $urandom(32'h8959);
    inexact_flag = 0;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1;
    @(posedge clock_i);
    for (int i = 0; i < 100; i++) begin
      k = i < 12 ? 2 + i / 6 : $urandom % 4;
      a = i < 12 ? corner[i % 6] : $urandom >> ($urandom % 32);
      b = i % 5 == 0 ? a : $urandom >> ($urandom % 32);
      m = 7'($urandom);
      if (i % 3 == 0) a = i < 12 ? a : 32'(m);
      s = i < 12 ? 3'(1 + 3 * (i % 2)) : 3'(1 + $urandom % 5);
      gp = 1'($urandom);
      g = i < 12 || 1'($urandom);
      r = cvt(a);
      ex[i] = 32'hc0de0000 | 32'(i);
      if ((!gp || g) && (k < 2 || s == 3'h1 || s == 3'h4)) begin
        case (k)
          0: ex[i] = 32'(a >= b);
          1: ex[i] = 32'(a >= 32'(m));
          2: ex[i] = r[31:0];
          default: ex[i] = {30'h0, r[32], 1'b0};
        endcase
        if (k == 2) inexact_flag |= r[32];
      end
      iss(k, s, gp, g, a, b, m, 7'(i));
    end
    issue_valid_i <= 0;
    repeat (6) @(posedge clock_i);
    for (int i = 0; i < 50; i++) chk(pm.rf[i], ex[i]);
    for (int i = 50; i < 100; i++) chk(pm.rf[i], ex[i]);
    chk(32'(exc_flags_o), {30'h0, inexact_flag, 1'b0});
    $display("test random mix done");
    wr(`ADDR_FLAGS, 32'h0);
    wr(`ADDR_IRQ_STATUS, 32'h3);
    iss(3, 3'h4, 1'b0, 1'b0, 32'hffffffff, 32'h0, 7'h0, 7'h70);
    iss(2, 3'h1, 1'b1, 1'b0, 32'hfffffffd, 32'h0, 7'h0, 7'h71);
    iss(2, 3'h4, 1'b0, 1'b0, 32'h80000000, 32'h0, 7'h0, 7'h72);
    iss(2, 3'h1, 1'b1, 1'b1, 32'h7fffffff, 32'h0, 7'h0, 7'h73);
    issue_valid_i <= 0;
    @(posedge clock_i);
    #1 chk(32'(falu_wr_en_o), 32'h1);
    chk(32'(falu_wr_dest_o), 32'h72);
    chk(falu_wr_data_o, 32'h4f000000);
    chk(32'(exc_flags_o), 32'h0);
    @(posedge clock_i);
    #1 chk(32'(exc_flags_o), 32'h2);
    chk(falu_wr_data_o, 32'h4effffff);
    chk(pm.rf[112], 32'h2);
    chk(pm.rf[113], 32'hc0de0071);
    @(posedge clock_i);
    fp_flag_set_i <= 6'h10;
    @(posedge clock_i);
    fp_flag_set_i <= 6'h00;
    #1 chk(32'(exc_flags_o), 32'h12);
    @(posedge clock_i);
    rd(`ADDR_IRQ_STATUS, v);
    chk(v, 32'h1);
    wr(`ADDR_FLAGS, 32'h0);
    chk(32'(exc_flags_o), 32'h0);
    $display("test flags done");
    wr(`ADDR_IRQ_MASK, 32'h3);
    chk(32'(irq_o), 32'h1);
    rd(`ADDR_IRQ_MASK, v);
    chk(v, 32'h3);
    wr(`ADDR_IRQ_STATUS, 32'h1);
    chk(32'(irq_o), 32'h0);
    iss(2, 3'h2, 1'b0, 1'b0, 32'h5, 32'h0, 7'h0, 7'h74);
    issue_valid_i <= 0;
    repeat (5) @(posedge clock_i);
    chk(pm.rf[116], 32'hc0de0074);
    chk(32'(irq_o), 32'h1);
    rd(8'h0c, v);
    chk(v, 32'h0);
    wr(`ADDR_IRQ_MASK, 32'h0);
    chk(32'(irq_o), 32'h0);
    $display("test interrupts done");
    wrap_up;
  end
endmodule
